// ==== rtl/rps_pkg.sv ====
// Constants and types for the panel video-input and power-sequencing block.
// Assumes one 250 MHz system clock; every panel pin arrives asynchronously.
//
// Behaviour
// - Display starts on the 14th frame-sync falling edge after shutdown falls.
// - Starting edge is moved earlier by the two-bit blank-lines select.
// - Display turns off on the 6th frame-sync falling edge after shutdown rises.
// - A colour-depth change takes effect at the next frame-sync falling edge.
package rps_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // System clock and pixel-clock watchdog
    localparam int         CLK_PERIOD_PS = 4000;
    localparam int         PIX_LOST_NS   = 1000;
    localparam int         LOST_W        = 9;
    // Longest time, rounds down
    localparam logic [8:0] PIX_LOST_CYC  = 9'((PIX_LOST_NS * 1000) / CLK_PERIOD_PS);

    ////////////////////////////////////////////////////////////////////////////
    // Frame-sync edge counts for power sequencing
    localparam logic [3:0] ON_EDGES  = 4'hE;
    localparam logic [3:0] OFF_EDGES = 4'h6;
    localparam logic [3:0] EDGE_ONE  = 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Sync phase window, in pixel clocks counted after the frame-sync fall
    localparam int         PHASE_W   = 9;
    localparam logic [8:0] PHASE_MAX = 9'h0F0;
    localparam logic [8:0] PHASE_SAT = 9'h1FF;

    ////////////////////////////////////////////////////////////////////////////
    // Pixel assembly and buffering
    localparam int         PIX_W     = 24;
    localparam int         BYTE_W    = 8;
    localparam logic [1:0] SER_LAST  = 2'h2;
    localparam int         BUF_DEPTH = 2;

    // Power sequencing states
    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_WAIT_ON,
        PWR_ON,
        PWR_WAIT_OFF
    } rps_pwr_type;

endpackage

// ==== rtl/rps_buf.sv ====
// Small FIFO between pixel assembly and the downstream pixel consumer.
// Assumes writer and reader share clk; words held in registers.
`timescale 1ns/1ns
`default_nettype none
module rps_buf
    import rps_pkg::*;
#(
    parameter int WIDTH = 25,
    parameter int DEPTH = BUF_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wrPtr_r;
    logic [PTR_W-1:0] rdPtr_r;
    logic [CNT_W-1:0] count_r;
    logic             doWrite;
    logic             doRead;

    ////////////////////////////////////////////////////////////////////////////
    // Handshakes
    assign inReady  = (count_r != CNT_FULL);
    assign outValid = (count_r != '0);
    assign doWrite  = inValid && inReady;
    assign doRead   = outValid && outReady;
    assign outData  = mem_r[rdPtr_r];

    // Storage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (doWrite) begin
            mem_r[wrPtr_r] <= inData;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (doWrite) begin
                wrPtr_r <= (wrPtr_r == PTR_LAST) ? '0 : wrPtr_r + 1'b1;
            end
            if (doRead) begin
                rdPtr_r <= (rdPtr_r == PTR_LAST) ? '0 : rdPtr_r + 1'b1;
            end
            if (doWrite && !doRead) begin
                count_r <= count_r + 1'b1;
            end else if (doRead && !doWrite) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    a_buf_hold_word: assert property (@(posedge clk) disable iff (!nrst)
        outValid && !outReady |=> outValid && $stable(outData))
        else $error("buffered word changed while stalled");
    a_buf_fill_bound: assert property (@(posedge clk) disable iff (!nrst)
        count_r == CNT_FULL && !doRead |=> count_r == CNT_FULL && !inReady)
        else $error("full buffer lost or accepted a word");

endmodule // rps_buf
`default_nettype wire

// ==== rtl/rps_seq.sv ====
// Panel video input: pin synchronisers, shutdown power sequencing,
// colour-mode switching, sync phase check and pixel assembly.
// Assumes all panel pins are asynchronous to clk; consumer may stall.
`timescale 1ns/1ns
`default_nettype none
module rps_seq
    import rps_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             pixelClock,
    input  wire logic             frameSyncN,
    input  wire logic             lineSyncN,
    input  wire logic             shutdownPin,
    input  wire logic             dataValid,
    input  wire logic             colorDepthSelect,
    input  wire logic             serialMode,
    input  wire logic [1:0]       blankLinesSelect,
    input  wire logic [PIX_W-1:0] pixelData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [PIX_W-1:0] outData,
    output logic                  outLowColor,
    output logic                  displayOn,
    output logic                  clockPresent,
    output logic                  syncPhaseErr,
    output logic                  pixelDropped
);

    localparam int SYNC_W = PIX_W + 9;

    logic [SYNC_W-1:0] rawPins;
    logic [SYNC_W-1:0] meta_r;
    logic [SYNC_W-1:0] sync_r;
    logic              pcIn, vsIn, hsIn, shutIn, dvIn, cmIn, serialIn;
    logic [1:0]        bltIn;
    logic [PIX_W-1:0]  dataIn;

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers, one per pin bit
    assign rawPins = {pixelClock, frameSyncN, lineSyncN, shutdownPin, dataValid,
                      colorDepthSelect, serialMode, blankLinesSelect, pixelData};

    for (genvar b = 0; b < SYNC_W; b++) begin : g_sync
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                meta_r[b] <= 1'b0;
                sync_r[b] <= 1'b0;
            end else begin
                meta_r[b] <= rawPins[b];
                sync_r[b] <= meta_r[b];
            end
        end
    end

    assign {pcIn, vsIn, hsIn, shutIn, dvIn, cmIn, serialIn, bltIn, dataIn} = sync_r;

    ////////////////////////////////////////////////////////////////////////////
    // Pixel clock edge detect and sync edge detect on pixel ticks
    logic pcPrev_r;
    logic vsLast_r;
    logic hsLast_r;
    logic pixTick;
    logic vsFall;
    logic hsFall;

    assign pixTick = pcIn && !pcPrev_r;
    assign vsFall  = pixTick && vsLast_r && !vsIn;
    assign hsFall  = pixTick && hsLast_r && !hsIn;

    // Previous levels, sync lines idle high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pcPrev_r <= 1'b0;
            vsLast_r <= 1'b1;
            hsLast_r <= 1'b1;
        end else begin
            pcPrev_r <= pcIn;
            if (pixTick) begin
                vsLast_r <= vsIn;
                hsLast_r <= hsIn;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pixel clock watchdog
    logic [LOST_W-1:0] lostCnt_r;
    logic              clockPresent_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lostCnt_r      <= '0;
            clockPresent_r <= 1'b0;
        end else if (pixTick) begin
            lostCnt_r      <= '0;
            clockPresent_r <= 1'b1;
        end else if (lostCnt_r == PIX_LOST_CYC) begin
            clockPresent_r <= 1'b0;
        end else begin
            lostCnt_r <= lostCnt_r + 1'b1;
        end
    end

    assign clockPresent = clockPresent_r;

    ////////////////////////////////////////////////////////////////////////////
    // Power sequencing on frame-sync falling edges
    rps_pwr_type state_r;
    logic [3:0]  edgeCnt_r;
    logic [3:0]  startTarget;

    assign startTarget = ON_EDGES - {2'h0, bltIn};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r   <= PWR_OFF;
            edgeCnt_r <= '0;
        end else if (!clockPresent_r) begin
            state_r   <= PWR_OFF;
            edgeCnt_r <= '0;
        end else begin
            case (state_r)
                PWR_OFF: begin
                    if (pixTick && !shutIn) begin
                        state_r   <= PWR_WAIT_ON;
                        edgeCnt_r <= '0;
                    end
                end
                PWR_WAIT_ON: begin
                    if (pixTick && shutIn) begin
                        state_r <= PWR_OFF;
                    end else if (vsFall) begin
                        if (edgeCnt_r + EDGE_ONE == startTarget) begin
                            state_r <= PWR_ON;
                        end else begin
                            edgeCnt_r <= edgeCnt_r + EDGE_ONE;
                        end
                    end
                end
                PWR_ON: begin
                    if (pixTick && shutIn) begin
                        state_r   <= PWR_WAIT_OFF;
                        edgeCnt_r <= '0;
                    end
                end
                default: begin
                    if (vsFall) begin
                        if (edgeCnt_r + EDGE_ONE == OFF_EDGES) begin
                            state_r <= PWR_OFF;
                        end else begin
                            edgeCnt_r <= edgeCnt_r + EDGE_ONE;
                        end
                    end
                end
            endcase
        end
    end

    // Display visible while on or counting down to off
    assign displayOn = (state_r == PWR_ON) || (state_r == PWR_WAIT_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // Colour mode latched at frame boundary
    logic cmActive_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmActive_r <= 1'b0;
        end else if (vsFall) begin
            cmActive_r <= cmIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sync phase check between frame-sync and line-sync falls
    logic [PHASE_W-1:0] phaseCnt_r;
    logic               phaseArmed_r;
    logic               syncPhaseErr_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phaseCnt_r     <= '0;
            phaseArmed_r   <= 1'b0;
            syncPhaseErr_r <= 1'b0;
        end else if (vsFall) begin
            phaseCnt_r   <= '0;
            phaseArmed_r <= !hsFall;
            if (hsFall) begin
                syncPhaseErr_r <= 1'b1;
            end
        end else if (pixTick && phaseArmed_r) begin
            if (hsFall) begin
                phaseArmed_r   <= 1'b0;
                syncPhaseErr_r <= (phaseCnt_r >= PHASE_MAX);
            end else if (phaseCnt_r != PHASE_SAT) begin
                phaseCnt_r <= phaseCnt_r + 1'b1;
            end
        end
    end

    assign syncPhaseErr = syncPhaseErr_r;

    ////////////////////////////////////////////////////////////////////////////
    // Pixel assembly: parallel word per tick, or three serial bytes
    logic [1:0]       byteCnt_r;
    logic [PIX_W-1:0] asm_r;
    logic             pushValid_r;
    logic [PIX_W:0]   pushData_r;
    logic             bufReady;
    logic             takeByte;

    assign takeByte = pixTick && dvIn && displayOn;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            byteCnt_r   <= '0;
            asm_r       <= '0;
            pushValid_r <= 1'b0;
            pushData_r  <= '0;
        end else begin
            pushValid_r <= 1'b0;
            if (hsFall) begin
                byteCnt_r <= '0;
            end else if (takeByte && serialIn) begin
                asm_r <= {asm_r[PIX_W-BYTE_W-1:0], dataIn[BYTE_W-1:0]};
                if (byteCnt_r == SER_LAST) begin
                    byteCnt_r   <= '0;
                    pushValid_r <= 1'b1;
                    pushData_r  <= {cmActive_r, asm_r[PIX_W-BYTE_W-1:0],
                                    dataIn[BYTE_W-1:0]};
                end else begin
                    byteCnt_r <= byteCnt_r + 1'b1;
                end
            end else if (takeByte) begin
                pushValid_r <= 1'b1;
                pushData_r  <= {cmActive_r, dataIn};
            end
        end
    end

    // Overflow pulse when the buffer cannot take a word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pixelDropped <= 1'b0;
        end else begin
            pixelDropped <= pushValid_r && !bufReady;
        end
    end

    rps_buf #(
        .WIDTH (PIX_W + 1),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk      (clk),
        .nrst     (nrst),
        .inValid  (pushValid_r),
        .inReady  (bufReady),
        .inData   (pushData_r),
        .outValid (outValid),
        .outReady (outReady),
        .outData  ({outLowColor, outData})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_last_on_edge;
        clockPresent_r && state_r == PWR_WAIT_ON && vsFall && !shutIn
            && edgeCnt_r + EDGE_ONE == startTarget;
    endsequence
    sequence s_last_off_edge;
        clockPresent_r && state_r == PWR_WAIT_OFF && vsFall
            && edgeCnt_r + EDGE_ONE == OFF_EDGES;
    endsequence

    a_start_on_edge: assert property (s_last_on_edge |=> displayOn)
        else $error("display did not start on counted edge");
    a_start_target: assert property (
        (state_r == PWR_WAIT_ON ##1 state_r == PWR_ON)
            |-> $past(edgeCnt_r) + EDGE_ONE == $past(startTarget) && $past(vsFall))
        else $error("display started on wrong edge");
    a_off_sixth: assert property (s_last_off_edge |=> !displayOn ##1 !pushValid_r)
        else $error("display not off at sixth edge");
    a_off_cause: assert property ($fell(displayOn) && clockPresent_r
            |-> $past(vsFall) && $past(edgeCnt_r) + EDGE_ONE == OFF_EDGES)
        else $error("display went off without sixth edge");
    a_no_clk_blank: assert property (!clockPresent_r |=> !displayOn)
        else $error("display on without pixel clock");
    a_blank_state: assert property (!displayOn |=> !pushValid_r)
        else $error("pixel pushed while blanked");
    a_mode_vsync: assert property ($changed(cmActive_r) |-> $past(vsFall))
        else $error("colour mode changed off frame edge");
    a_phase_flag: assert property (pixTick && phaseArmed_r && hsFall && !vsFall
            && phaseCnt_r >= PHASE_MAX |=> syncPhaseErr ##1 syncPhaseErr)
        else $error("late line sync not flagged");
    a_serial_three: assert property (pushValid_r && $past(serialIn)
            |-> $past(byteCnt_r) == SER_LAST)
        else $error("serial pixel pushed before third byte");

endmodule // rps_seq
`default_nettype wire

// ==== verification/rps_host.sv ====
// Host video source model: pixel clock, frame and line syncs, pixel data.
// Assumes the bench sets frame length and line-sync offset in pixel clocks.
`timescale 1ns/1ns
`default_nettype none
module rps_host
    import rps_pkg::*;
(
    input  wire logic             run,
    input  wire logic [8:0]       lineOffset,
    input  wire logic [8:0]       frameLen,
    output logic                  pixelClock,
    output logic                  frameSyncN,
    output logic                  lineSyncN,
    output logic                  dataValid,
    output logic      [PIX_W-1:0] pixelData,
    output var int                frameCount
);
    logic pclk   = 1'b0;
    int   pixIdx = 1;

    ////////////////////////////////////////////////////////////////////////////
    // 64 ns pixel clock, parks low when stopped
    initial begin
        forever begin
            #32;
            pclk = (run || pclk) ? ~pclk : 1'b0;
        end
    end
    assign pixelClock = pclk;

    ////////////////////////////////////////////////////////////////////////////
    // Idle levels, then syncs and data move on the falling pixel-clock edge
    initial begin
        frameSyncN = 1'b1;
        lineSyncN  = 1'b1;
        dataValid  = 1'b0;
        pixelData  = 24'h000000;
        frameCount = 0;
        forever begin
            @(negedge pclk);
            pixIdx = (pixIdx + 1 >= int'(frameLen)) ? 0 : pixIdx + 1;
            if (pixIdx == 0) begin
                frameCount++;
            end
            frameSyncN <= (pixIdx != 0);
            lineSyncN  <= (pixIdx != int'(lineOffset));
            dataValid  <= (pixIdx >= 8) && (pixIdx < 16);
            // Serial bytes ride on the low byte; idle data is inverted
            pixelData  <= (pixIdx >= 8 && pixIdx < 16) ?
                          {8'(pixIdx + 8'h40), 8'(pixIdx + 8'h80), 8'(pixIdx)} : ~pixelData;
        end
    end
endmodule // rps_host
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the panel power-sequencing and pixel input block.
// Assumes rps_host as video source; consumer side driven here.
`timescale 1ns/1ns
`default_nettype none
module tb
    import rps_pkg::*;
;
    localparam int LIMIT = 80000;
    logic             clk;
    logic             nrst;
    logic             run;
    logic             shutdownPin;
    logic             colorDepthSelect;
    logic             serialMode;
    logic             outReady;
    logic [1:0]       blankLinesSelect;
    logic [8:0]       lineOffset;
    logic [8:0]       frameLen;
    logic             pixelClock;
    logic             frameSyncN;
    logic             lineSyncN;
    logic             dataValid;
    logic [PIX_W-1:0] pixelData;
    int               frameCount;
    logic             outValid;
    logic [PIX_W-1:0] outData;
    logic             outLowColor;
    logic             displayOn;
    logic             clockPresent;
    logic             syncPhaseErr;
    logic             pixelDropped;
    int               errCount       = 0;
    int               samplesChecked = 0;
    int               cycleCount     = 0;

    rps_host hostSrc (.run(run), .lineOffset(lineOffset), .frameLen(frameLen),
        .pixelClock(pixelClock), .frameSyncN(frameSyncN), .lineSyncN(lineSyncN),
        .dataValid(dataValid), .pixelData(pixelData), .frameCount(frameCount));

    rps_seq dut (.clk(clk), .nrst(nrst), .pixelClock(pixelClock), .frameSyncN(frameSyncN),
        .lineSyncN(lineSyncN), .shutdownPin(shutdownPin), .dataValid(dataValid),
        .colorDepthSelect(colorDepthSelect), .serialMode(serialMode),
        .blankLinesSelect(blankLinesSelect), .pixelData(pixelData), .outValid(outValid),
        .outReady(outReady), .outData(outData), .outLowColor(outLowColor),
        .displayOn(displayOn), .clockPresent(clockPresent), .syncPhaseErr(syncPhaseErr),
        .pixelDropped(pixelDropped));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycleCount++;
        if (cycleCount == LIMIT) begin
            errCount++;
            $display("Error cycleCount expected below %0d got %0d", LIMIT, cycleCount);
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare and wait helpers
    task automatic check_bit(input string what, input logic exp, input logic got);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("Error %s expected %b got %b", what, exp, got);
        end
    endtask
    task automatic check_word(input string what, input logic [PIX_W-1:0] exp,
                              input logic [PIX_W-1:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("Error %s expected %h got %h", what, exp, got);
        end
    endtask
    task automatic check_count(input string what, input int exp, input int got);
        samplesChecked++;
        if (got != exp) begin
            errCount++;
            $display("Error %s expected %0d got %0d", what, exp, got);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_until(input int target);
        while (frameCount < target) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic pwr_on(input logic [1:0] blt);
        int base;
        blankLinesSelect = blt;
        wait_until(frameCount + 1);
        settle(100);
        shutdownPin = 1'b0;
        base = frameCount;
        wait_until(base + 13 - int'(blt));
        settle(100);
        check_bit("displayOn early", 1'b0, displayOn);
        wait_until(base + 14 - int'(blt));
        settle(30);
        check_bit("displayOn start", 1'b1, displayOn);
        check_bit("clockPresent", 1'b1, clockPresent);
    endtask
    task automatic pwr_off();
        int base;
        wait_until(frameCount + 1);
        settle(100);
        shutdownPin = 1'b1;
        base = frameCount;
        wait_until(base + 5);
        settle(100);
        check_bit("displayOn hold", 1'b1, displayOn);
        wait_until(base + 6);
        settle(30);
        check_bit("displayOn off", 1'b0, displayOn);
    endtask
    task automatic grab(input logic colorPin, input logic expColor, input int stall,
                        input int nWords, input int nDrops);
        int               words = 0;
        int               drops = 0;
        int               p;
        logic [PIX_W-1:0] expW;
        wait_until(frameCount + 1);
        settle(10);
        colorDepthSelect = colorPin;
        outReady = (stall == 0);
        for (int c = 0; c < 480; c++) begin
            if (c == stall) outReady = 1'b1;
            if (pixelDropped === 1'b1) drops++;
            if (outValid === 1'b1 && outReady) begin
                p = serialMode ? 8 + 3 * words : 8 + words;
                expW = serialMode ? {8'(p), 8'(p + 1), 8'(p + 2)} :
                       {8'(p + 8'h40), 8'(p + 8'h80), 8'(p)};
                check_word("outData", expW, outData);
                check_bit("outLowColor", expColor, outLowColor);
                words++;
            end
            @(negedge clk);
        end
        check_count("words", nWords, words);
        check_count("pixelDropped", nDrops, drops);
    endtask
    task automatic phase(input logic [8:0] off, input logic [8:0] len, input logic exp);
        lineOffset = off;
        frameLen = len;
        wait_until(frameCount + 2);
        settle(20);
        check_bit("syncPhaseErr", exp, syncPhaseErr);
    endtask
    task automatic clock_loss();
        run = 1'b0;
        settle(300);
        check_bit("displayOn lost clock", 1'b0, displayOn);
        check_bit("clockPresent", 1'b0, clockPresent);
    endtask
    // Reset only after the six-frame power-down interval
    task automatic mid_reset();
        nrst = 1'b0;
        settle(3);
        check_bit("displayOn in reset", 1'b0, displayOn);
        check_bit("clockPresent in reset", 1'b0, clockPresent);
        check_bit("outValid in reset", 1'b0, outValid);
        nrst = 1'b1;
        settle(2);
        check_bit("displayOn after reset", 1'b0, displayOn);
        check_word("outData after reset", 24'h000000, outData);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        nrst = 1'b0;
        run = 1'b1;
        shutdownPin = 1'b1;
        colorDepthSelect = 1'b0;
        serialMode = 1'b0;
        outReady = 1'b1;
        blankLinesSelect = 2'h0;
        lineOffset = 9'h004;
        frameLen = 9'h020;
        settle(3);
        check_bit("outValid", 1'b0, outValid);
        check_bit("displayOn", 1'b0, displayOn);
        check_bit("clockPresent", 1'b0, clockPresent);
        check_bit("syncPhaseErr", 1'b0, syncPhaseErr);
        check_bit("pixelDropped", 1'b0, pixelDropped);
        check_word("outData", 24'h000000, outData);
        nrst = 1'b1;
        pwr_on(2'h3);
        grab(1'b1, 1'b0, 0, 8, 0);
        grab(1'b1, 1'b1, 400, 2, 6);
        serialMode = 1'b1;
        grab(1'b0, 1'b1, 0, 2, 0);
        grab(1'b0, 1'b0, 0, 2, 0);
        serialMode = 1'b0;
        pwr_off();
        mid_reset();
        phase(9'h0F0, 9'h104, 1'b0);
        phase(9'h0F1, 9'h104, 1'b1);
        phase(9'h004, 9'h020, 1'b0);
        for (int b = 0; b < 3; b++) begin
            pwr_on(2'(b));
            if (b < 2) pwr_off();
        end
        clock_loss();
        complete_run();
    end
endmodule // tb
`default_nettype wire
